// ---- vccs_defs.svh ----
`ifndef VCCS_DEFS_SVH
`define VCCS_DEFS_SVH

// ------------------------------------------------------------
// Implementation parameters
// ------------------------------------------------------------
`define VCCS_MAX_ELEMENT_BITS   32
`define VCCS_REG_WIDTH_BITS     128
`define VCCS_REG_WIDTH_LIMIT    65536
`define VCCS_NUM_VREGS          32
`define VCCS_HYP_PRESENT        1'b1

// ------------------------------------------------------------
// Vector CSR numbers
// ------------------------------------------------------------
`define VCCS_ADDR_START_INDEX   12'h008
`define VCCS_ADDR_SAT_FLAG      12'h009
`define VCCS_ADDR_ROUND_MODE    12'h00a
`define VCCS_ADDR_RSVD_LO       12'h00b
`define VCCS_ADDR_RSVD_HI       12'h00e
`define VCCS_ADDR_CTRL_STATUS   12'h00f
`define VCCS_ADDR_ELEM_COUNT    12'hc20
`define VCCS_ADDR_TYPE_CONFIG   12'hc21
`define VCCS_ADDR_BYTE_COUNT    12'hc22

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define VCCS_CTX_HI             10
`define VCCS_CTX_LO             9
`define VCCS_SD_BIT             31
`define VCCS_CS_SAT_BIT         0
`define VCCS_CS_RM_HI           2
`define VCCS_CS_RM_LO           1
`define VCCS_TYPE_ILL_BIT       31

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define VCCS_RST_START_INDEX    16'h0000
`define VCCS_RST_SAT_FLAG       1'b0
`define VCCS_RST_ROUND_MODE     2'h0
`define VCCS_RST_ELEM_COUNT     32'h0000_0000
`define VCCS_RST_TYPE_CONFIG    32'h8000_0000

`endif

// ---- vccs_pkg.sv ----
package vccs_pkg;

  // Context state encoding, floating-point convention
  typedef enum logic [1:0] {
    VCCS_CTX_OFF     = 2'h0,
    VCCS_CTX_INITIAL = 2'h1,
    VCCS_CTX_CLEAN   = 2'h2,
    VCCS_CTX_DIRTY   = 2'h3
  } vccs_ctx_e;

  typedef enum logic [1:0] {
    VCCS_REQ_CSR_READ,
    VCCS_REQ_CSR_WRITE,
    VCCS_REQ_VEC_OP,
    VCCS_REQ_VEC_CFG
  } vccs_req_kind_e;

  typedef struct packed {
    logic           valid;
    vccs_req_kind_e kind;
    logic [11:0]    csr_addr;
    logic [31:0]    wdata;
    logic           modifies;
    logic           vreg_we;
    logic [4:0]     vreg_idx;
    logic [127:0]   vreg_data;
    logic [31:0]    cfg_count;
    logic [31:0]    cfg_type;
  } vccs_req_s;

  typedef struct packed {
    logic        valid;
    logic        illegal;
    logic [31:0] rdata;
  } vccs_resp_s;

  typedef struct packed {
    logic      we;
    vccs_ctx_e value;
  } vccs_ctx_wr_s;

endpackage : vccs_pkg

// ---- vccs_vreg_file.sv ----
`timescale 1ns/100ps
`include "vccs_defs.svh"

module vccs_vreg_file
  import vccs_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         we,
  input  wire logic [4:0]   wr_idx,
  input  wire logic [127:0] wr_data,
  input  wire logic [4:0]   rd_idx,
  output logic      [127:0] rd_data
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [`VCCS_REG_WIDTH_BITS-1:0] vreg [`VCCS_NUM_VREGS];

  always_ff @(posedge clock) begin
    if (we) begin
      vreg[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    rd_data <= vreg[rd_idx];
  end

endmodule : vccs_vreg_file

// ---- vccs_top.sv ----
`timescale 1ns/100ps
`include "vccs_defs.svh"

// Summary of operation
// - Element width fixed, power of two
// - Register width power of two, bounded
// - Thirty-two registers of register width
// - Seven vector CSRs at fixed numbers
// - Byte count reads register width/8
// - CSR numbers 0x00b-0x00e stay unassigned
// - Context field at bits 10:9, mirrored
// - Off machine field traps vector accesses
// - Vector state change sets Dirty, except start_index zeroed by a vector op without modifies or vreg_we
// - Dirty may be set without change
// - Machine summary bit set when Dirty
// - Machine field exists without vector enable
// - Guest field at bits 10:9 with hypervisor
// - Guest mode traps if either Off
// - Guest mode change dirties both fields
// - Guest summary bit set when Dirty
// - Guest field exists without vector enable
// - Type CSR changed only by config

module vccs_top
  import vccs_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire vccs_req_s    req,
  output vccs_resp_s        resp,
  input  wire logic         guest_mode,
  input  wire logic         vector_enable,
  input  wire vccs_ctx_wr_s mach_ctx_wr,
  input  wire vccs_ctx_wr_s guest_ctx_wr,
  input  wire logic         mach_sd_other,
  input  wire logic         guest_sd_other,
  output logic      [31:0]  mach_status_view,
  output logic      [31:0]  super_status_view,
  output logic      [31:0]  guest_status_view,
  input  wire logic [4:0]   vreg_rd_idx,
  output logic      [127:0] vreg_rd_data
);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  localparam int ELEM_BITS = `VCCS_MAX_ELEMENT_BITS;
  localparam int REG_BITS  = `VCCS_REG_WIDTH_BITS;
  localparam logic ELEM_OK = (ELEM_BITS >= 8) && ((ELEM_BITS & (ELEM_BITS - 1)) == 0);
  localparam logic REG_OK  = (REG_BITS >= ELEM_BITS) && ((REG_BITS & (REG_BITS - 1)) == 0)
                             && (REG_BITS <= `VCCS_REG_WIDTH_LIMIT);
  localparam logic [31:0] BYTE_COUNT = 32'(REG_BITS / 8);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  vccs_ctx_e   mach_ctx;
  vccs_ctx_e   guest_ctx;
  logic [15:0] start_index;
  logic        sat_flag;
  logic [1:0]  round_mode;
  logic [31:0] elem_count;
  logic [31:0] type_config;
  logic        resp_valid;
  logic        resp_illegal;
  logic [31:0] resp_rdata;

  logic        blocked;
  logic        addr_known;
  logic        addr_writable;
  logic        illegal;
  logic        accepted;
  logic        changes_state;
  logic [31:0] read_value;
  logic        guest_active;
  vccs_ctx_e   next_mach_ctx;
  vccs_ctx_e   next_guest_ctx;

  assign guest_active = guest_mode && `VCCS_HYP_PRESENT;

  // ------------------------------------------------------------
  // Trap decision
  // ------------------------------------------------------------
  always_comb begin
    blocked = (mach_ctx == VCCS_CTX_OFF) || !ELEM_OK || !REG_OK;
    if (guest_active && (guest_ctx == VCCS_CTX_OFF)) begin
      blocked = 1'b1;
    end
  end

  always_comb begin
    addr_known    = 1'b0;
    addr_writable = 1'b0;
    read_value    = 32'h0000_0000;
    case (req.csr_addr)
      `VCCS_ADDR_START_INDEX: begin
        addr_known    = 1'b1;
        addr_writable = 1'b1;
        read_value    = {16'h0000, start_index};
      end
      `VCCS_ADDR_SAT_FLAG: begin
        addr_known    = 1'b1;
        addr_writable = 1'b1;
        read_value    = {31'h0000_0000, sat_flag};
      end
      `VCCS_ADDR_ROUND_MODE: begin
        addr_known    = 1'b1;
        addr_writable = 1'b1;
        read_value    = {30'h0000_0000, round_mode};
      end
      `VCCS_ADDR_CTRL_STATUS: begin
        addr_known    = 1'b1;
        addr_writable = 1'b1;
        read_value    = {29'h0000_0000, round_mode, sat_flag};
      end
      `VCCS_ADDR_ELEM_COUNT: begin
        addr_known = 1'b1;
        read_value = elem_count;
      end
      `VCCS_ADDR_TYPE_CONFIG: begin
        addr_known = 1'b1;
        read_value = type_config;
      end
      `VCCS_ADDR_BYTE_COUNT: begin
        addr_known = 1'b1;
        read_value = BYTE_COUNT;
      end
      default: begin
        addr_known = 1'b0;
      end
    endcase
  end

  always_comb begin
    illegal = 1'b0;
    case (req.kind)
      VCCS_REQ_CSR_READ: begin
        illegal = blocked || !addr_known;
      end
      VCCS_REQ_CSR_WRITE: begin
        illegal = blocked || !addr_writable;
      end
      VCCS_REQ_VEC_OP,
      VCCS_REQ_VEC_CFG: begin
        illegal = blocked;
      end
      default: begin
        illegal = 1'b1;
      end
    endcase
  end

  assign accepted = req.valid && !illegal;

  // Writes, config and register updates change state; config always dirties
  always_comb begin
    changes_state = 1'b0;
    case (req.kind)
      VCCS_REQ_CSR_WRITE: changes_state = 1'b1;
      VCCS_REQ_VEC_CFG:   changes_state = 1'b1;
      VCCS_REQ_VEC_OP:    changes_state = req.modifies || req.vreg_we;
      default:            changes_state = 1'b0;
    endcase
    changes_state = changes_state && accepted;
  end

  // ------------------------------------------------------------
  // Context state fields
  // ------------------------------------------------------------
  always_comb begin
    next_mach_ctx = mach_ctx;
    if (mach_ctx_wr.we) begin
      next_mach_ctx = mach_ctx_wr.value;
    end
    if (changes_state) begin
      next_mach_ctx = VCCS_CTX_DIRTY;
    end
  end

  always_comb begin
    next_guest_ctx = guest_ctx;
    if (guest_ctx_wr.we && `VCCS_HYP_PRESENT) begin
      next_guest_ctx = guest_ctx_wr.value;
    end
    if (changes_state && guest_active) begin
      next_guest_ctx = VCCS_CTX_DIRTY;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mach_ctx <= VCCS_CTX_OFF;
    end else begin
      mach_ctx <= next_mach_ctx;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      guest_ctx <= VCCS_CTX_OFF;
    end else begin
      guest_ctx <= next_guest_ctx;
    end
  end

  // ------------------------------------------------------------
  // Status views
  // ------------------------------------------------------------
  always_comb begin
    mach_status_view = 32'h0000_0000;
    mach_status_view[`VCCS_CTX_HI:`VCCS_CTX_LO] = mach_ctx;
    mach_status_view[`VCCS_SD_BIT] = (mach_ctx == VCCS_CTX_DIRTY) || mach_sd_other;
    super_status_view = mach_status_view;
  end

  always_comb begin
    guest_status_view = 32'h0000_0000;
    if (`VCCS_HYP_PRESENT) begin
      guest_status_view[`VCCS_CTX_HI:`VCCS_CTX_LO] = guest_ctx;
      guest_status_view[`VCCS_SD_BIT] = (guest_ctx == VCCS_CTX_DIRTY) || guest_sd_other;
    end
  end

  // ------------------------------------------------------------
  // Read-write vector CSRs
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      start_index <= `VCCS_RST_START_INDEX;
    end else if (accepted && req.kind == VCCS_REQ_CSR_WRITE
                 && req.csr_addr == `VCCS_ADDR_START_INDEX) begin
      start_index <= req.wdata[15:0];
    end else if (accepted && req.kind == VCCS_REQ_VEC_OP) begin
      start_index <= 16'h0000;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sat_flag <= `VCCS_RST_SAT_FLAG;
    end else if (accepted && req.kind == VCCS_REQ_CSR_WRITE) begin
      if (req.csr_addr == `VCCS_ADDR_SAT_FLAG) begin
        sat_flag <= req.wdata[0];
      end else if (req.csr_addr == `VCCS_ADDR_CTRL_STATUS) begin
        sat_flag <= req.wdata[`VCCS_CS_SAT_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      round_mode <= `VCCS_RST_ROUND_MODE;
    end else if (accepted && req.kind == VCCS_REQ_CSR_WRITE) begin
      if (req.csr_addr == `VCCS_ADDR_ROUND_MODE) begin
        round_mode <= req.wdata[1:0];
      end else if (req.csr_addr == `VCCS_ADDR_CTRL_STATUS) begin
        round_mode <= req.wdata[`VCCS_CS_RM_HI:`VCCS_CS_RM_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // Length and type, set only by config instructions
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      elem_count  <= `VCCS_RST_ELEM_COUNT;
      type_config <= `VCCS_RST_TYPE_CONFIG;
    end else if (accepted && req.kind == VCCS_REQ_VEC_CFG) begin
      elem_count  <= req.cfg_count;
      type_config <= req.cfg_type;
    end
  end

  // ------------------------------------------------------------
  // Vector register file
  // ------------------------------------------------------------
  vccs_vreg_file u_vreg_file (
    .clock   (clock),
    .we      (accepted && req.kind == VCCS_REQ_VEC_OP && req.vreg_we),
    .wr_idx  (req.vreg_idx),
    .wr_data (req.vreg_data),
    .rd_idx  (vreg_rd_idx),
    .rd_data (vreg_rd_data)
  );

  // ------------------------------------------------------------
  // Response
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resp_valid   <= 1'b0;
      resp_illegal <= 1'b0;
      resp_rdata   <= 32'h0000_0000;
    end else begin
      resp_valid   <= req.valid;
      resp_illegal <= req.valid && illegal;
      resp_rdata   <= (accepted && req.kind == VCCS_REQ_CSR_READ) ? read_value : 32'h0000_0000;
    end
  end

  assign resp = '{valid: resp_valid, illegal: resp_illegal, rdata: resp_rdata};

endmodule : vccs_top

// ---- vccs_top_monitor.sv ----
`timescale 1ns/100ps
// ------------
// Port checker
// ------------
module vccs_top_monitor
  import vccs_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire vccs_req_s   req,
  input wire vccs_resp_s  resp,
  input wire logic        guest_mode,
  input wire logic        mach_sd_other,
  input wire logic        guest_sd_other,
  input wire logic [31:0] mach_status_view,
  input wire logic [31:0] super_status_view,
  input wire logic [31:0] guest_status_view
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [1:0] mc;
  logic [1:0] gc;
  logic       ok;
  logic       rd;
  assign mc = mach_status_view[10:9];
  assign gc = guest_status_view[10:9];
  assign ok = mc != 2'h0 && (!guest_mode || gc != 2'h0);
  assign rd = req.valid && req.kind == VCCS_REQ_CSR_READ;
  a_resp_follows: assert property (req.valid |=> resp.valid)
    else $error("no response one cycle after request");
  a_no_spurious: assert property (!req.valid |=> !resp.valid)
    else $error("response without request");
  a_off_traps: assert property (req.valid && !ok |=> resp.illegal && resp.rdata == 32'h0)
    else $error("access with context off not trapped");
  a_rsvd_traps: assert property (rd && req.csr_addr inside {[12'h00b:12'h00e]} |=> resp.illegal)
    else $error("reserved csr read not trapped");
  a_ro_write: assert property (req.valid && req.kind == VCCS_REQ_CSR_WRITE
    && req.csr_addr inside {[12'hc20:12'hc22]} |=> resp.illegal)
    else $error("read-only csr write accepted");
  a_byte_count: assert property (rd && ok && req.csr_addr == 12'hc22
    |=> !resp.illegal && resp.rdata == 32'h0000_0010)
    else $error("byte count wrong");
  a_cfg_dirty: assert property (req.valid && ok && req.kind == VCCS_REQ_VEC_CFG
    |=> mc == 2'h3 && (!$past(guest_mode) || gc == 2'h3))
    else $error("config did not dirty context");
  a_view_mirror: assert property (super_status_view == mach_status_view)
    else $error("supervisor view differs");
  a_mach_sd: assert property (mach_status_view[31] == (mc == 2'h3 || mach_sd_other))
    else $error("machine summary bit wrong");
  a_guest_sd: assert property (guest_status_view[31] == (gc == 2'h3 || guest_sd_other))
    else $error("guest summary bit wrong");
  c_trap: cover property (req.valid && !ok ##1 resp.illegal);
  c_cfg: cover property (req.valid && ok && req.kind == VCCS_REQ_VEC_CFG);
  c_guest: cover property (guest_mode && gc == 2'h3);
endmodule : vccs_top_monitor

bind vccs_top vccs_top_monitor u_mon (.clock, .rst_n, .req, .resp, .guest_mode,
  .mach_sd_other, .guest_sd_other, .mach_status_view, .super_status_view,
  .guest_status_view);

// ---- vccs_pipe_model.sv ----
`timescale 1ns/100ps
// ------------------------
// Pipeline request source
// ------------------------
module vccs_pipe_model
  import vccs_pkg::*;
(
  input  wire logic       clock,
  output vccs_req_s       req,
  input  wire vccs_resp_s resp
);
  initial req = '0;
  // Idle fields carry the inverse so stale values never look valid
  task automatic xfer(input vccs_req_s r, output vccs_resp_s s);
    @(posedge clock);
    req <= r;
    @(posedge clock);
    req <= {1'b0, ~r[$bits(vccs_req_s)-2:0]};
    @(posedge clock);
    s = resp;
  endtask : xfer
endmodule : vccs_pipe_model

// ---- test_vector_context_status_csrs.sv ----
`timescale 1ns/100ps
`include "vccs_defs.svh"
// ----------
// Testbench
// ----------
module test_vector_context_status_csrs
  import vccs_pkg::*;
;
  logic         clock;
  logic         rst_n;
  vccs_req_s    req;
  vccs_resp_s   resp;
  logic         guest_mode;
  vccs_ctx_wr_s mach_ctx_wr;
  vccs_ctx_wr_s guest_ctx_wr;
  logic         mach_sd_other;
  logic         guest_sd_other;
  logic [31:0]  mv;
  logic [31:0]  sv;
  logic [31:0]  gv;
  logic [4:0]   vreg_rd_idx;
  logic [127:0] vreg_rd_data;
  vccs_req_s    r;
  int           fail_count = 0;
  int           check_count = 0;

  vccs_pipe_model pipe (.clock(clock), .req(req), .resp(resp));
  vccs_top DUT (.clock(clock), .rst_n(rst_n), .req(req), .resp(resp),
    .guest_mode(guest_mode), .vector_enable(1'b0), .mach_ctx_wr(mach_ctx_wr),
    .guest_ctx_wr(guest_ctx_wr), .mach_sd_other(mach_sd_other),
    .guest_sd_other(guest_sd_other),
    .mach_status_view(mv), .super_status_view(sv), .guest_status_view(gv),
    .vreg_rd_idx(vreg_rd_idx), .vreg_rd_data(vreg_rd_data));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic results();
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic check(string name, logic [127:0] seen, logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic vccs_req_s mk(vccs_req_kind_e k, logic [11:0] a, logic [31:0] d);
    mk = '0;
    mk.valid = 1'b1;
    mk.kind = k;
    mk.csr_addr = a;
    mk.wdata = d;
  endfunction : mk

  task automatic access(vccs_req_s q, logic ill, logic [31:0] exp);
    vccs_resp_s s;
    pipe.xfer(q, s);
    check("resp_valid", s.valid, 1'b1);
    check("illegal", s.illegal, ill);
    check("rdata", s.rdata, exp);
  endtask : access

  task automatic ctx_set(logic g, vccs_ctx_e v);
    @(posedge clock);
    if (g) guest_ctx_wr <= '{1'b1, v};
    else mach_ctx_wr <= '{1'b1, v};
    @(posedge clock);
    mach_ctx_wr.we <= 1'b0;
    guest_ctx_wr.we <= 1'b0;
    @(posedge clock);
  endtask : ctx_set

  initial begin
    repeat (2000) @(posedge clock);
    fail_count++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    guest_mode = 1'b0;
    mach_ctx_wr = '0;
    guest_ctx_wr = '0;
    mach_sd_other = 1'b0;
    guest_sd_other = 1'b0;
    vreg_rd_idx = 5'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check("mach_view", mv, 32'h0);
    access(mk(VCCS_REQ_CSR_READ, 12'hc22, 0), 1'b1, 0);
    ctx_set(1'b0, VCCS_CTX_INITIAL);
    check("mach_view", mv, 32'h0000_0200);
    check("super_view", sv, 32'h0000_0200);
    access(mk(VCCS_REQ_CSR_READ, 12'hc22, 0), 1'b0, `VCCS_REG_WIDTH_BITS / 8);
    access(mk(VCCS_REQ_CSR_READ, 12'hc21, 0), 1'b0, 32'h8000_0000);
    for (int a = 12'h00b; a <= 12'h00e; a++) access(mk(VCCS_REQ_CSR_READ, a[11:0], 0), 1'b1, 0);
    for (int a = 12'hc20; a <= 12'hc22; a++) access(mk(VCCS_REQ_CSR_WRITE, a[11:0], 1), 1'b1, 0);
    access(mk(VCCS_REQ_CSR_WRITE, 12'h009, 1), 1'b0, 0);
    check("mach_view", mv, 32'h8000_0600);
    access(mk(VCCS_REQ_CSR_READ, 12'h00f, 0), 1'b0, 1);
    access(mk(VCCS_REQ_CSR_WRITE, 12'h00f, 6), 1'b0, 0);
    access(mk(VCCS_REQ_CSR_READ, 12'h00a, 0), 1'b0, 3);
    access(mk(VCCS_REQ_CSR_READ, 12'h009, 0), 1'b0, 0);
    access(mk(VCCS_REQ_CSR_WRITE, 12'h008, 5), 1'b0, 0);
    access(mk(VCCS_REQ_CSR_READ, 12'h008, 0), 1'b0, 5);
    r = mk(VCCS_REQ_VEC_CFG, 0, 0);
    r.cfg_count = 32'h7;
    r.cfg_type = 32'h12;
    access(r, 1'b0, 0);
    access(mk(VCCS_REQ_CSR_READ, 12'hc20, 0), 1'b0, 7);
    access(mk(VCCS_REQ_CSR_READ, 12'hc21, 0), 1'b0, 32'h12);
    r = mk(VCCS_REQ_VEC_OP, 0, 0);
    r.vreg_we = 1'b1;
    r.vreg_idx = 5'h1f;
    r.vreg_data = {4{32'h5a3c_96e1}};
    access(r, 1'b0, 0);
    vreg_rd_idx <= 5'h1f;
    repeat (2) @(posedge clock);
    check("vreg", vreg_rd_data, {4{32'h5a3c_96e1}});
    access(mk(VCCS_REQ_CSR_READ, 12'h008, 0), 1'b0, 0);
    ctx_set(1'b0, VCCS_CTX_CLEAN);
    check("mach_view", mv, 32'h0000_0400);
    mach_sd_other <= 1'b1;
    @(posedge clock);
    check("mach_view", mv, 32'h8000_0400);
    mach_sd_other <= 1'b0;
    guest_mode <= 1'b1;
    access(mk(VCCS_REQ_CSR_READ, 12'hc22, 0), 1'b1, 0);
    ctx_set(1'b1, VCCS_CTX_INITIAL);
    check("guest_view", gv, 32'h0000_0200);
    access(mk(VCCS_REQ_CSR_WRITE, 12'h009, 1), 1'b0, 0);
    check("mach_view", mv, 32'h8000_0600);
    check("guest_view", gv, 32'h8000_0600);
    ctx_set(1'b1, VCCS_CTX_CLEAN);
    check("guest_view", gv, 32'h0000_0400);
    guest_sd_other <= 1'b1;
    @(posedge clock);
    check("guest_view", gv, 32'h8000_0400);
    guest_sd_other <= 1'b0;
    ctx_set(1'b0, VCCS_CTX_OFF);
    access(mk(VCCS_REQ_CSR_READ, 12'hc22, 0), 1'b1, 0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check("mach_view", mv, 32'h0);
    check("guest_view", gv, 32'h0);
    access(mk(VCCS_REQ_CSR_READ, 12'h009, 0), 1'b1, 0);
    results();
  end
endmodule : test_vector_context_status_csrs
